// >>> src/chip_select_route_and_stretch.sv
// How it works
// - No routing bits: each select pin follows only its own area.
// - General one to program alone: program pin covers both, general one silent.
// - General two to program alone: program pin covers both, general two silent.
// - Both to program: program pin covers all three, both general pins silent.
// - General one to two alone: general two pin covers both, general one silent.
// - One-to-two plus two-to-program: general one pin keeps its own area.
// - Select pins change only with the bus clock edges or a write to the route polarity bits.
// - A nonzero stretch holds the bus clock high one to three extra cycles.
// - Stretch applies only to accesses inside the stretched select's area.
// - Internal timing ticks keep running unaffected during a stretch.
// - Each of the four selects owns a 2-bit field in one register.
// - The field is a binary count: 0 none, up to 3 cycles.
// - Routed selects are ORed onto the receiving pin; source pin goes idle.
// - Area hits arrive already resolved by the existing priority ordering.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "cs_route_cfg.svh"

module chip_select_route_and_stretch #(
    parameter int HALF_CYCLES = `BUS_HALF_CYCLES
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    input  wire logic        i_io_area,
    input  wire logic        i_general_one_area,
    input  wire logic        i_general_two_area,
    input  wire logic        i_program_area,
    output logic             o_bus_clk,
    output logic             o_io_select_pin,
    output logic             o_general_select_one_pin,
    output logic             o_general_select_two_pin,
    output logic             o_program_select_pin,
    output logic             o_timer_tick
);

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);
    localparam logic [7:0] FULL_LAST = 8'(2 * HALF_CYCLES - 1);

    localparam cs_route_pkg::state_t RESET_STATE = '{
        st:       cs_route_pkg::ST_LOW,
        cnt:      8'h00,
        extra:    2'h0,
        e_clk:    1'b0,
        tick:     1'b0,
        tick_cnt: 8'h00,
        act:      4'h0,
        pin:      4'hf,
        stretch:  `STRETCH_RESET,
        route:    `ROUTE_RESET,
        dph_wr:   1'b0,
        dph_idx:  8'h00,
        rdata:    32'h0000_0000,
        hready:   1'b1
    };

    cs_route_pkg::state_t s_r;
    cs_route_pkg::state_t s_nxt;
    logic [3:0]           hit;

    assign hit = {i_program_area, i_general_two_area, i_general_one_area, i_io_area};

    function automatic logic [3:0] route_sel(input logic [3:0] h, input logic [7:0] r);
        logic [3:0] a;
        a = h;
        if (r[`FLD_G1_TO_PROG]) begin
            a[`SEL_PROG] = a[`SEL_PROG] | h[`SEL_G1];
            a[`SEL_G1]   = 1'b0;
        end else if (r[`FLD_G1_TO_G2] && !r[`FLD_G2_TO_PROG]) begin
            a[`SEL_G2] = a[`SEL_G2] | h[`SEL_G1];
            a[`SEL_G1] = 1'b0;
        end
        // general one to two is ignored when two is routed away
        if (r[`FLD_G2_TO_PROG]) begin
            a[`SEL_PROG] = a[`SEL_PROG] | h[`SEL_G2];
            a[`SEL_G2]   = 1'b0;
        end
        return a;
    endfunction : route_sel

    function automatic logic [1:0] stretch_of(input logic [3:0] h, input logic [7:0] f);
        logic [1:0] m;
        m = 2'h0;
        for (int i = 0; i < 4; i++) begin
            if (h[i] && f[2*i +: 2] > m) begin
                m = f[2*i +: 2];
            end
        end
        return m;
    endfunction : stretch_of

    function automatic logic [7:0] idx_of(input logic [31:0] a);
        if (a[31:10] != 22'h0 || a[1:0] != 2'h0) begin
            return 8'hff;
        end
        return a[9:2];
    endfunction : idx_of

    always_comb begin
        s_nxt = s_r;

        s_nxt.tick = 1'b0;
        if (s_r.tick_cnt == FULL_LAST) begin
            s_nxt.tick_cnt = 8'h00;
            s_nxt.tick     = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 8'h01;
        end

        // Write data phase; narrow writes still take the low byte lane.
        if (s_r.dph_wr) begin
            if (s_r.dph_idx == `STRETCH_IDX) begin
                s_nxt.stretch = i_hwdata[7:0];
            end else if (s_r.dph_idx == `ROUTE_IDX) begin
                s_nxt.route = i_hwdata[7:0] & `ROUTE_MASK;
            end
        end

        // Bus clock and select sequencing.
        case (s_r.st)
            cs_route_pkg::ST_LOW: begin
                if (s_r.cnt == HALF_LAST) begin
                    s_nxt.cnt   = 8'h00;
                    s_nxt.st    = cs_route_pkg::ST_HIGH;
                    // selects latched on the rising edge
                    s_nxt.e_clk = 1'b1;
                    s_nxt.act   = route_sel(hit, s_nxt.route);
                    s_nxt.extra = stretch_of(hit, s_nxt.stretch);
                end else begin
                    s_nxt.cnt = s_r.cnt + 8'h01;
                end
            end
            cs_route_pkg::ST_HIGH: begin
                if (s_r.cnt == HALF_LAST) begin
                    s_nxt.cnt = 8'h00;
                    if (s_r.extra != 2'h0) begin
                        s_nxt.st = cs_route_pkg::ST_STRETCH;
                    end else begin
                        s_nxt.st    = cs_route_pkg::ST_LOW;
                        s_nxt.e_clk = 1'b0;
                        s_nxt.act   = 4'h0;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt + 8'h01;
                end
            end
            cs_route_pkg::ST_STRETCH: begin
                if (s_r.cnt == FULL_LAST) begin
                    s_nxt.cnt   = 8'h00;
                    // one whole bus cycle per count
                    s_nxt.extra = s_r.extra - 2'h1;
                    if (s_r.extra == 2'h1) begin
                        s_nxt.st    = cs_route_pkg::ST_LOW;
                        s_nxt.e_clk = 1'b0;
                        s_nxt.act   = 4'h0;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt + 8'h01;
                end
            end
            default: begin
                s_nxt.st    = cs_route_pkg::ST_LOW;
                s_nxt.cnt   = 8'h00;
                s_nxt.e_clk = 1'b0;
                s_nxt.act   = 4'h0;
            end
        endcase

        // polarity after routing; a 0 bit means active low
        s_nxt.pin = ~(s_nxt.act ^ s_nxt.route[`FLD_POL +: 4]);

        // Address phase. Stretch and route read data come from the updated values so that a read right
        // after a write returns the new contents without a wait state.
        s_nxt.dph_wr = 1'b0;
        if (i_hsel && i_hready && i_htrans[1]) begin
            s_nxt.dph_wr  = i_hwrite;
            s_nxt.dph_idx = idx_of(i_haddr);
            if (!i_hwrite) begin
                case (idx_of(i_haddr))
                    `STRETCH_IDX: s_nxt.rdata = {24'h0, s_nxt.stretch};
                    `ROUTE_IDX:   s_nxt.rdata = {24'h0, s_nxt.route};
                    `STATUS_IDX:  s_nxt.rdata = {24'h0, s_r.st, s_r.extra, s_r.act};
                    default:      s_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_r <= RESET_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_hrdata                 = s_r.rdata;
    assign o_hreadyout              = s_r.hready;
    assign o_hresp                  = 1'b0;
    assign o_bus_clk                = s_r.e_clk;
    assign o_io_select_pin          = s_r.pin[`SEL_IO];
    assign o_general_select_one_pin = s_r.pin[`SEL_G1];
    assign o_general_select_two_pin = s_r.pin[`SEL_G2];
    assign o_program_select_pin     = s_r.pin[`SEL_PROG];
    assign o_timer_tick             = s_r.tick;

    // Helper logic read only by the checks below.
    logic [15:0] high_len_r;
    logic [1:0]  ext0_r;
    logic [7:0]  gap_r;
    logic        seen_r;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            high_len_r <= 16'h0000;
            ext0_r     <= 2'h0;
            gap_r      <= 8'h00;
            seen_r     <= 1'b0;
        end else begin
            high_len_r <= s_r.e_clk ? high_len_r + 16'h0001 : 16'h0000;
            if (s_r.e_clk && s_r.st == cs_route_pkg::ST_HIGH && s_r.cnt == 8'h00) begin
                ext0_r <= s_r.extra;
            end
            gap_r  <= s_r.tick ? 8'h00 : gap_r + 8'h01;
            seen_r <= seen_r | s_r.tick;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    sequence access_start_s;
        $rose(s_r.e_clk);
    endsequence

    sequence access_end_s;
        $fell(s_r.e_clk);
    endsequence

    route_off_a: assert property (access_start_s ##0 (s_r.route[2:0] == 3'b000) |-> s_r.act == $past(hit)) else $error("Unrouted select mismatch.");

    g1_prog_a: assert property (access_start_s ##0 (s_r.route[2:0] == 3'b010 || s_r.route[2:0] == 3'b011)
        |-> !s_r.act[1] && s_r.act[3] == ($past(hit[3]) | $past(hit[1]))) else $error("G1 to program wrong.");

    g2_prog_a: assert property (access_start_s ##0 (s_r.route[2:1] == 2'b10)
        |-> !s_r.act[2] && s_r.act[3] == ($past(hit[3]) | $past(hit[2]))) else $error("G2 to program wrong.");

    both_prog_a: assert property (access_start_s ##0 (s_r.route[2:1] == 2'b11)
        |-> s_r.act[2:1] == 2'b00 && s_r.act[3] == |{$past(hit[3]), $past(hit[2]), $past(hit[1])})
        else $error("Both to program wrong.");

    g1_g2_a: assert property (access_start_s ##0 (s_r.route[2:0] == 3'b001)
        |-> !s_r.act[1] && s_r.act[2] == ($past(hit[2]) | $past(hit[1]))) else $error("G1 to G2 wrong.");

    g1_kept_a: assert property (access_start_s ##0 (s_r.route[2:0] == 3'b101)
        |-> s_r.act[1] == $past(hit[1])) else $error("G1 lost its own area.");

    sel_sync_a: assert property ($changed(s_r.act) |-> $changed(s_r.e_clk)) else $error("Select moved off clock edge.");

    stretch_len_a: assert property (access_end_s |-> high_len_r == 16'(HALF_CYCLES * (1 + 2 * ext0_r)))
        else $error("Bus clock high time wrong.");

    no_hit_a: assert property (access_start_s ##0 ($past(hit) == 4'h0) |-> s_r.extra == 2'h0)
        else $error("Stretch outside any area.");

    io_field_a: assert property (access_start_s ##0 ($past(hit) == 4'h1) |-> s_r.extra == s_r.stretch[1:0])
        else $error("Stretch field not honoured.");

    tick_run_a: assert property (s_r.tick && seen_r |-> gap_r == FULL_LAST) else $error("Tick period disturbed.");

endmodule : chip_select_route_and_stretch

`default_nettype wire

// >>> src/cs_route_cfg.svh
`ifndef CS_ROUTE_CFG_SVH
`define CS_ROUTE_CFG_SVH

// Register indices; the AHB byte address is four times the index.
`define STRETCH_IDX      8'h5a
`define ROUTE_IDX        8'h5b
`define STATUS_IDX       8'h5c

`define STRETCH_RESET    8'h00
`define ROUTE_RESET      8'h00
`define ROUTE_MASK       8'hf7

// Select positions, also the stretch field order (two bits each).
`define SEL_IO           0
`define SEL_G1           1
`define SEL_G2           2
`define SEL_PROG         3

// Route register fields.
`define FLD_G1_TO_G2     0
`define FLD_G1_TO_PROG   1
`define FLD_G2_TO_PROG   2
`define FLD_POL          4

// Bus clock half period.
`define CLK_PERIOD_NS    40
`define BUS_HALF_NS      80
`define BUS_HALF_CYCLES  ((`BUS_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> src/cs_route_pkg.sv
package cs_route_pkg;

    typedef enum logic [1:0] {
        ST_LOW     = 2'b00,
        ST_HIGH    = 2'b01,
        ST_STRETCH = 2'b10
    } bus_phase_t;

    typedef struct packed {
        bus_phase_t  st;
        logic [7:0]  cnt;
        logic [1:0]  extra;
        logic        e_clk;
        logic        tick;
        logic [7:0]  tick_cnt;
        logic [3:0]  act;
        logic [3:0]  pin;
        logic [7:0]  stretch;
        logic [7:0]  route;
        logic        dph_wr;
        logic [7:0]  dph_idx;
        logic [31:0] rdata;
        logic        hready;
    } state_t;

endpackage : cs_route_pkg

// >>> tb/ext_periph_model.sv
`timescale 1ns/100ps
`default_nettype none
module ext_periph_model (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_bus_clk,
    input  wire logic [3:0] i_pins,
    output logic      [7:0] o_last_len,
    output logic      [3:0] o_last_pins
);
    logic       prev_r;
    logic [7:0] cnt_r;
    logic [3:0] cap_r;

    // A slow peripheral only sees the bus clock, so it times each high phase and latches the pins at its start.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            prev_r      <= 1'b0;
            cnt_r       <= 8'h00;
            cap_r       <= 4'h0;
            o_last_len  <= 8'h00;
            o_last_pins <= 4'h0;
        end else begin
            prev_r <= i_bus_clk;
            if (i_bus_clk && !prev_r) begin
                cnt_r <= 8'h01;
                cap_r <= i_pins;
            end else if (i_bus_clk) begin
                cnt_r <= cnt_r + 8'h01;
            end else if (prev_r) begin
                o_last_len  <= cnt_r;
                o_last_pins <= cap_r;
            end
        end
    end
endmodule : ext_periph_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int HALF = 2;
    logic        i_clk, i_reset, hsel, hwrite, hready, hresp, bus_clk, tick, mon_en, bus_q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, v;
    logic [3:0]  area, pins, pins_q, last_pins, pol;
    logic [7:0]  last_len;
    int          err_count, comparisons, cycles, seed, gap;
    bit          seen;

    chip_select_route_and_stretch #(.HALF_CYCLES(HALF)) DUT (
        .i_clk(i_clk), .i_reset(i_reset), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_io_area(area[0]), .i_general_one_area(area[1]),
        .i_general_two_area(area[2]), .i_program_area(area[3]), .o_bus_clk(bus_clk),
        .o_io_select_pin(pins[0]), .o_general_select_one_pin(pins[1]),
        .o_general_select_two_pin(pins[2]), .o_program_select_pin(pins[3]), .o_timer_tick(tick));

    ext_periph_model PEER (.i_clk(i_clk), .i_reset(i_reset), .i_bus_clk(bus_clk), .i_pins(pins),
        .o_last_len(last_len), .o_last_pins(last_pins));

    task report_and_stop;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        @(posedge i_clk);
        hsel   <= 1'b1;
        haddr  <= addr;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge i_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wdata;
        do @(posedge i_clk); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
        chk("response", 32'h0, {31'h0, hresp});
    endtask : bus

    // Polarity takes hold on the pins at once, so the pin-timing watch is paused around it.
    task set_route(input logic [7:0] val);
        mon_en <= 1'b0;
        bus(1'b1, 32'h16c, {24'h0, val});
        repeat (2) @(posedge i_clk);
        mon_en <= 1'b1;
    endtask : set_route

    // The bus clock is looked at on the falling edge, where it has settled, and the task returns on the next rising edge.
    task wait_bus(input logic lvl);
        do @(negedge i_clk); while (bus_clk !== lvl);
        @(posedge i_clk);
    endtask : wait_bus

    // Hits are set in the high phase and cleared in the low phase after the access, so the next rising edge is sure to take them.
    task access(input logic [3:0] a);
        wait_bus(1'b1);
        area <= a;
        wait_bus(1'b0);
        wait_bus(1'b1);
        wait_bus(1'b0);
        area <= 4'h0;
        @(posedge i_clk);
    endtask : access

    function automatic logic [3:0] exp_act(input logic [2:0] r, input logic [3:0] a);
        exp_act[0] = a[0];
        exp_act[1] = a[1] & !r[1] & !(r[0] & !r[2]);
        exp_act[2] = !r[2] & (a[2] | (a[1] & r[0] & !r[1]));
        exp_act[3] = a[3] | (a[1] & r[1]) | (a[2] & r[2]);
    endfunction : exp_act

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // Outputs are watched on the falling edge so that no check races the flops that launch them.
    always @(negedge i_clk) begin
        cycles++;
        if (cycles > 20000) begin
            err_count++;
            report_and_stop;
        end
        if (mon_en && pins !== pins_q) chk("pin change off bus edge", {31'h0, ~bus_q}, {31'h0, bus_clk});
        pins_q <= pins;
        bus_q  <= bus_clk;
        gap++;
        if (tick === 1'b1 && !i_reset) begin
            if (seen) chk("tick spacing", 32'(2 * HALF), 32'(gap));
            gap  = 0;
            seen = 1'b1;
        end
    end

    initial begin
        seed = 32'h7e61;
        {hsel, hwrite, htrans, haddr, hwdata, area, mon_en, seen, gap} = '0;
        hsize   = 3'h2;
        i_reset = 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        bus(1'b0, 32'h168, 32'h0);
        chk("stretch reset", 32'h0, rd);
        bus(1'b0, 32'h16c, 32'h0);
        chk("route reset", 32'h0, rd);
        bus(1'b1, 32'h200, $random(seed));
        bus(1'b0, 32'h200, 32'h0);
        chk("unmapped", 32'h0, rd);
        v = $random(seed);
        bus(1'b1, 32'h168, v);
        bus(1'b0, 32'h168, 32'h0);
        chk("stretch rw", {24'h0, v[7:0]}, rd);
        bus(1'b1, 32'h16c, v);
        bus(1'b0, 32'h16c, 32'h0);
        chk("route rw", {24'h0, v[7:0] & 8'hf7}, rd);
        bus(1'b1, 32'h168, 32'h0);
        for (int r = 0; r < 8; r++) begin
            for (int k = 0; k < 4; k++) begin
                pol = 4'($random(seed));
                set_route({pol, 1'b0, 3'(r)});
                access(4'h1 << k);
                chk("pins at rise", {28'h0, ~(exp_act(3'(r), 4'h1 << k) ^ pol)}, {28'h0, last_pins});
                chk("pins when low", {28'h0, ~pol}, {28'h0, pins});
            end
        end
        set_route(8'hf0);
        for (int i = 0; i < 16; i++) begin
            v = $random(seed);
            v[2 * (i % 4) +: 2] = 2'(i / 4);
            bus(1'b1, 32'h168, v);
            access(4'h1 << (i % 4));
            chk("high length", 32'(HALF * (1 + 2 * (i / 4))), {24'h0, last_len});
        end
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire
